//--- src/mtc_consts.svh
// constants of the motor timer counter core: offsets, fields, resets
// assumes a 32-bit axi4-lite slave with byte addresses below 0x40
//
// Behaviour
// R1: up mode counts zero to reload, wraps to zero, flags overflow, repeats.
// R2: software writes direction 0 for up, 1 for down when edge aligned.
// R3: down mode counts reload to zero, reloads, flags underflow, repeats.
// R4: software update event in up mode clears the counter.
// R5: software update event in down mode loads the reload value.
// R6: center mode counts up then down; overflow at top, underflow at zero.
// R7: in center mode direction bit is read only, tracks hardware direction.
// R8: software update event in center mode clears counter in either direction.
// R9: overflow or underflow sets the update flag in interrupt status.
// R10: repetition zero fires update each event, else only when counter hits zero.
// R11: repetition decrements on overflow up, underflow down, both in center.
// R12: prescaler runs on bus clock when slave off or modes 4, 5, 6.
// R13: slave mode 7 counts each rising edge of the selected trigger.
// R14: trigger source 0 is the software bit; with mode 7 it updates only.
// R15: other trigger sources give one pulse per rising edge.
// R16: 16-bit prescaler divides by 1 through 65536.
// R17: restart edge reinitialises counter, prescaler; update unless disabled.
// R18: pause mode counts while trigger high, holds value while low.
// R19: software must not use channel-0 both-edge signal as pause trigger.
// R20: trigger mode edge resumes stopped counter; never stops; software never resumes (a cfg write of cen still resumes it here).
// R21: master trigger output selected by master mode drives linked slave timers.
// R22: holds 16-bit counter, four compare values, reload, 8-bit repetition.
// R23: counter steps only at prescaler terminal count; prescaler restarts at zero.
// R24: reload, prescaler and repetition preloads take effect at update events.
`ifndef MTC_CONSTS_SVH
`define MTC_CONSTS_SVH

`define MTC_OFF_CFG    8'h00
`define MTC_OFF_MODE   8'h04
`define MTC_OFF_TRG    8'h08
`define MTC_OFF_EVG    8'h0c
`define MTC_OFF_ISR    8'h10
`define MTC_OFF_CNT    8'h14
`define MTC_OFF_PSC    8'h18
`define MTC_OFF_RELOAD 8'h1c
`define MTC_OFF_REP    8'h20
`define MTC_OFF_CMP0   8'h24
`define MTC_OFF_CMP1   8'h28
`define MTC_OFF_CMP2   8'h2c
`define MTC_OFF_CMP3   8'h30

`define MTC_CFG_CEN    0
`define MTC_CFG_DIR    1
`define MTC_CFG_CMS    2
`define MTC_CFG_UDIS   3
`define MTC_EVG_UG     0
`define MTC_ISR_UIF    0
`define MTC_ISR_TIF    1

`define MTC_SMS_RESTART 3'h4
`define MTC_SMS_PAUSE   3'h5
`define MTC_SMS_TRIGGER 3'h6
`define MTC_SMS_EXTCLK  3'h7
`define MTC_TSRC_SOFT   3'h0

`define MTC_RST_RELOAD 16'hffff
`define MTC_RESP_OKAY  2'h0
`define MTC_RESP_SLVERR 2'h2

`endif

//--- src/mtc_core.sv
// time base, slave, trigger and master control of the motor timer counter
// assumes an axi4-lite master on I_MCLK; I_TRIG_IN comes from other timers
// on unrelated logic and is therefore synchronised here
`timescale 1ns/1ns
`include "mtc_consts.svh"

module mtc_core
   import mtc_pkg::*;
(
   input  wire logic        I_MCLK,
   input  wire logic        I_RSTN,
   input  wire logic [6:0]  I_TRIG_IN,
   input  wire logic        I_AWVALID,
   output logic             O_AWREADY,
   input  wire logic [7:0]  I_AWADDR,
   input  wire logic        I_WVALID,
   output logic             O_WREADY,
   input  wire logic [31:0] I_WDATA,
   input  wire logic [3:0]  I_WSTRB,
   output logic             O_BVALID,
   input  wire logic        I_BREADY,
   output logic [1:0]       O_BRESP,
   input  wire logic        I_ARVALID,
   output logic             O_ARREADY,
   input  wire logic [7:0]  I_ARADDR,
   output logic             O_RVALID,
   input  wire logic        I_RREADY,
   output logic [31:0]      O_RDATA,
   output logic [1:0]       O_RRESP,
   output logic             O_MTRIG
);

   // ****************************************************************
   // helpers
   // ****************************************************************
   // lanes 0 and 1 only: no register here is wider than 16 bits
   function automatic logic [15:0] wm16(input logic [15:0] o,
                                       input logic [31:0] d,
                                       input logic [3:0]  b);
      wm16 = {b[1] ? d[15:8] : o[15:8], b[0] ? d[7:0] : o[7:0]};
   endfunction

   function automatic logic mapped(input logic [7:0] a);
      mapped = (a[1:0] == 2'h0) && (a <= `MTC_OFF_CMP3);
   endfunction

   function automatic logic [31:0] rd(input mtc_state_s t,
                                      input logic [7:0] a);
      rd = 32'h0;
      case (a)
         `MTC_OFF_CFG:    rd[3:0] = {t.udis, t.cms, t.dir, t.cen};
         `MTC_OFF_MODE:   rd[6:0] = {t.mms, 1'b0, t.sms};
         `MTC_OFF_TRG:    rd[2:0] = t.tsrc;
         `MTC_OFF_ISR:    rd[1:0] = {t.tif, t.uif};
         `MTC_OFF_CNT:    rd[15:0] = t.cnt;
         `MTC_OFF_PSC:    rd[15:0] = t.psc_pre;
         `MTC_OFF_RELOAD: rd[15:0] = t.arr_pre;
         `MTC_OFF_REP:    rd[7:0] = t.rep_pre;
         `MTC_OFF_CMP0:   rd[15:0] = t.cmp[15:0];
         `MTC_OFF_CMP1:   rd[15:0] = t.cmp[31:16];
         `MTC_OFF_CMP2:   rd[15:0] = t.cmp[47:32];
         `MTC_OFF_CMP3:   rd[15:0] = t.cmp[63:48];
         default:         rd = 32'h0;
      endcase
   endfunction

   mtc_state_s s;
   mtc_state_s n;

   // ****************************************************************
   // next state
   // ****************************************************************
   always_comb begin
      logic        wr;
      logic [7:0]  wa;
      logic        soft_ug;
      logic        clr_uif;
      logic        clr_tif;
      logic        ext_lvl;
      logic        ext_edge;
      logic        slv_lvl;
      logic        run;
      logic        tick;
      logic        restart;
      logic        reinit;
      logic        ug;
      logic        ovf;
      logic        udf;
      logic        hw_uev;
      logic        uev;
      logic [15:0] arr_new;
      logic [15:0] cmpv;
      logic [2:0]  ti;
      n        = s;
      wr       = 1'b0;
      wa       = 8'h0;
      soft_ug  = 1'b0;
      clr_uif  = 1'b0;
      clr_tif  = 1'b0;
      ovf      = 1'b0;
      udf      = 1'b0;
      hw_uev   = 1'b0;
      cmpv     = 16'h0;
      ti       = 3'h0;
      ext_lvl  = 1'b0;
      ext_edge = 1'b0;
      slv_lvl  = 1'b0;
      run      = 1'b0;
      tick     = 1'b0;
      restart  = 1'b0;
      reinit   = 1'b0;
      ug       = 1'b0;
      uev      = 1'b0;
      arr_new  = 16'h0;

      // the first stage feeds only the second; edges use the second
      n.trg_s1   = I_TRIG_IN;
      n.trg_s2   = s.trg_s1;
      n.trg_prev = s.trg_s2;

      // ************************************************************
      // axi4-lite write channel
      // ************************************************************
      if (I_AWVALID && s.awready) begin
         n.aw_full = 1'b1;
         n.aw_addr = I_AWADDR;
      end
      if (I_WVALID && s.wready) begin
         n.w_full = 1'b1;
         n.wdata  = I_WDATA;
         n.wstrb  = I_WSTRB;
      end
      if (s.bvalid && I_BREADY) begin
         n.bvalid = 1'b0;
      end
      if (n.aw_full && n.w_full && !s.bvalid) begin
         wr        = mapped(n.aw_addr);
         wa        = n.aw_addr;
         n.aw_full = 1'b0;
         n.w_full  = 1'b0;
         n.bvalid  = 1'b1;
         n.bresp   = wr ? `MTC_RESP_OKAY : `MTC_RESP_SLVERR;
      end

      if (wr) begin
         case (wa)
            `MTC_OFF_CFG: begin
               if (n.wstrb[0]) begin
                  n.cen  = n.wdata[`MTC_CFG_CEN];
                  n.cms  = n.wdata[`MTC_CFG_CMS];
                  n.udis = n.wdata[`MTC_CFG_UDIS];
                  // direction is hardware owned while center aligned
                  if (!s.cms && !n.wdata[`MTC_CFG_CMS]) begin
                     n.dir = n.wdata[`MTC_CFG_DIR]; // R2 R7
                  end
               end
            end
            `MTC_OFF_MODE: begin
               if (n.wstrb[0]) begin
                  n.sms = n.wdata[2:0];
                  n.mms = n.wdata[6:4];
               end
            end
            `MTC_OFF_TRG: begin
               if (n.wstrb[0]) begin
                  n.tsrc = n.wdata[2:0];
               end
            end
            `MTC_OFF_EVG: begin
               soft_ug = n.wstrb[0] && n.wdata[`MTC_EVG_UG];
            end
            `MTC_OFF_ISR: begin
               // write zero clears, as software acknowledges by writing 0
               clr_uif = n.wstrb[0] && !n.wdata[`MTC_ISR_UIF];
               clr_tif = n.wstrb[0] && !n.wdata[`MTC_ISR_TIF];
            end
            `MTC_OFF_CNT:    n.cnt = wm16(s.cnt, n.wdata, n.wstrb);
            `MTC_OFF_PSC:    n.psc_pre = wm16(s.psc_pre, n.wdata, n.wstrb);
            `MTC_OFF_RELOAD: n.arr_pre = wm16(s.arr_pre, n.wdata, n.wstrb);
            `MTC_OFF_REP: begin
               if (n.wstrb[0]) begin
                  n.rep_pre = n.wdata[7:0];
               end
            end
            `MTC_OFF_CMP0:   n.cmp[15:0] = wm16(s.cmp[15:0], n.wdata, n.wstrb);
            `MTC_OFF_CMP1:   n.cmp[31:16] = wm16(s.cmp[31:16], n.wdata, n.wstrb);
            `MTC_OFF_CMP2:   n.cmp[47:32] = wm16(s.cmp[47:32], n.wdata, n.wstrb);
            `MTC_OFF_CMP3:   n.cmp[63:48] = wm16(s.cmp[63:48], n.wdata, n.wstrb);
            default: begin
               n.bresp = `MTC_RESP_SLVERR;
            end
         endcase
      end

      // ************************************************************
      // trigger controller
      // ************************************************************
      // source 0 has no pin; index 0 keeps the select inside the bus
      if (s.tsrc == `MTC_TSRC_SOFT) begin
         ti = 3'h0;
      end else begin
         ti = s.tsrc - 3'h1;
      end
      ext_lvl  = s.trg_s2[ti];
      ext_edge = (s.tsrc != `MTC_TSRC_SOFT)
                 && s.trg_s2[ti] && !s.trg_prev[ti]; // R15
      // the software bit is a level source only, never an edge
      slv_lvl  = (s.tsrc == `MTC_TSRC_SOFT) ? soft_ug : ext_lvl; // R14

      // ************************************************************
      // slave controller and clock selection
      // ************************************************************
      restart = (s.sms == `MTC_SMS_RESTART) && ext_edge;
      if ((s.sms == `MTC_SMS_TRIGGER) && ext_edge) begin
         n.cen = 1'b1; // R20
      end
      run = s.cen && !((s.sms == `MTC_SMS_PAUSE) && !slv_lvl); // R18
      if (s.sms == `MTC_SMS_EXTCLK) begin
         tick = run && ext_edge; // R13 R14
      end else begin
         tick = run; // R12
      end

      ug      = soft_ug || (restart && !s.udis); // R17
      reinit  = soft_ug || restart; // R17
      arr_new = ug ? n.arr_pre : s.arr_act;

      // ************************************************************
      // prescaler and counter
      // ************************************************************
      if (reinit) begin
         n.psc_cnt = 16'h0;
         if (!s.cms && s.dir) begin
            n.cnt = arr_new; // R5
         end else begin
            n.cnt = 16'h0; // R4 R8
         end
      end else if (tick) begin
         if (s.psc_cnt == s.psc_act) begin
            n.psc_cnt = 16'h0; // R16 R23
            if (s.cms) begin
               if (!s.dir) begin
                  if (s.cnt >= s.arr_act) begin
                     ovf   = 1'b1; // R6
                     n.dir = 1'b1; // R7
                     n.cnt = (s.arr_act == 16'h0) ? 16'h0 : s.arr_act - 16'h1;
                  end else begin
                     n.cnt = s.cnt + 16'h1;
                  end
               end else begin
                  if (s.cnt == 16'h0) begin
                     udf   = 1'b1; // R6
                     n.dir = 1'b0; // R7
                     n.cnt = (s.arr_act == 16'h0) ? 16'h0 : 16'h1;
                  end else begin
                     n.cnt = s.cnt - 16'h1;
                  end
               end
            end else if (!s.dir) begin
               if (s.cnt >= s.arr_act) begin
                  ovf   = 1'b1; // R1
                  n.cnt = 16'h0; // R1
               end else begin
                  n.cnt = s.cnt + 16'h1;
               end
            end else begin
               if (s.cnt == 16'h0) begin
                  udf   = 1'b1; // R3
                  n.cnt = s.arr_act; // R3
               end else begin
                  n.cnt = s.cnt - 16'h1;
               end
            end
         end else begin
            n.psc_cnt = s.psc_cnt + 16'h1; // R23
         end
      end

      // ************************************************************
      // repetition and update events
      // ************************************************************
      if (ovf || udf) begin
         if (s.rep_cnt == 8'h0) begin
            hw_uev    = 1'b1; // R10
            // reload from the working copy; the update below replaces it with the new preload
            n.rep_cnt = s.rep_act;
         end else begin
            n.rep_cnt = s.rep_cnt - 8'h1; // R11
         end
      end
      uev = ug || hw_uev;
      if (uev) begin
         // preloads reach the working copies only here
         n.arr_act = n.arr_pre; // R24
         n.psc_act = n.psc_pre; // R24
         n.rep_act = n.rep_pre; // R24
         n.rep_cnt = n.rep_act; // R10
      end

      // ************************************************************
      // status flags: a hardware set beats a software clear
      // ************************************************************
      if (clr_uif) begin
         n.uif = 1'b0;
      end
      if (ovf || udf || ug) begin
         n.uif = 1'b1; // R9
      end
      if (clr_tif) begin
         n.tif = 1'b0;
      end
      if (ext_edge) begin
         n.tif = 1'b1;
      end

      // ************************************************************
      // master controller
      // ************************************************************
      // compare and enable modes hold a level; the other three give one-cycle pulses
      case (mtc_mms_e'(s.mms))
         MTC_MTRIG_SOFT_UG:   n.mtrig = soft_ug; // R21
         MTC_MTRIG_ENABLE:    n.mtrig = n.cen; // R21
         MTC_MTRIG_UPDATE:    n.mtrig = uev; // R21
         MTC_MTRIG_TRIG_EDGE: n.mtrig = ext_edge; // R21
         default: begin
            cmpv    = s.cmp[{s.mms[1:0], 4'h0} +: 16];
            n.mtrig = (s.cnt >= cmpv); // R21 R22
         end
      endcase

      // ************************************************************
      // axi4-lite read channel and ready flags
      // ************************************************************
      if (s.rvalid && I_RREADY) begin
         n.rvalid = 1'b0;
      end
      if (I_ARVALID && s.arready) begin
         n.rvalid = 1'b1;
         n.rdata  = rd(s, I_ARADDR);
         n.rresp  = mapped(I_ARADDR) ? `MTC_RESP_OKAY : `MTC_RESP_SLVERR;
      end
      n.arready = !n.rvalid;
      // one write at a time: both readies fall until the response is taken
      n.awready = !n.aw_full && !n.bvalid;
      n.wready  = !n.w_full && !n.bvalid;
   end

   // ****************************************************************
   // state register
   // ****************************************************************
   always_ff @(posedge I_MCLK or negedge I_RSTN) begin
      if (!I_RSTN) begin
         s         <= '0;
         s.arr_pre <= `MTC_RST_RELOAD;
         s.arr_act <= `MTC_RST_RELOAD;
         // readies start high so a request is taken at the first edge
         s.awready <= 1'b1;
         s.wready  <= 1'b1;
         s.arready <= 1'b1;
      end else begin
         s <= n;
      end
   end

   assign O_AWREADY = s.awready;
   assign O_WREADY  = s.wready;
   assign O_BVALID  = s.bvalid;
   assign O_BRESP   = s.bresp;
   assign O_ARREADY = s.arready;
   assign O_RVALID  = s.rvalid;
   assign O_RDATA   = s.rdata;
   assign O_RRESP   = s.rresp;
   assign O_MTRIG   = s.mtrig;

endmodule

//--- src/mtc_pkg.sv
// types of the motor timer counter core
// assumes mtc_consts.svh for every numeric constant
package mtc_pkg;

   typedef enum logic [2:0] {
      MTC_MTRIG_SOFT_UG,
      MTC_MTRIG_ENABLE,
      MTC_MTRIG_UPDATE,
      MTC_MTRIG_TRIG_EDGE,
      MTC_MTRIG_CMP0,
      MTC_MTRIG_CMP1,
      MTC_MTRIG_CMP2,
      MTC_MTRIG_CMP3
   } mtc_mms_e;

   typedef struct packed {
      logic [6:0]  trg_s1;
      logic [6:0]  trg_s2;
      logic [6:0]  trg_prev;
      logic        cen;
      logic        dir;
      logic        cms;
      logic        udis;
      logic [2:0]  sms;
      logic [2:0]  mms;
      logic [2:0]  tsrc;
      logic [15:0] cnt;
      logic [15:0] psc_cnt;
      logic [15:0] psc_pre;
      logic [15:0] psc_act;
      logic [15:0] arr_pre;
      logic [15:0] arr_act;
      logic [7:0]  rep_pre;
      logic [7:0]  rep_act;
      logic [7:0]  rep_cnt;
      logic [63:0] cmp;
      logic        uif;
      logic        tif;
      logic        mtrig;
      logic        aw_full;
      logic        w_full;
      logic [7:0]  aw_addr;
      logic [31:0] wdata;
      logic [3:0]  wstrb;
      logic        awready;
      logic        wready;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        arready;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
   } mtc_state_s;

endpackage

//--- test/mtc_core_assertions.sv
// bus handshake checker for the motor timer counter core
// assumes it is bound to mtc_core and sees only that module's ports
`timescale 1ns/1ns
`include "mtc_consts.svh"

module mtc_core_chk (
   input wire logic        I_MCLK,
   input wire logic        I_RSTN,
   input wire logic        I_AWVALID,
   input wire logic        O_AWREADY,
   input wire logic [7:0]  I_AWADDR,
   input wire logic        I_WVALID,
   input wire logic        O_WREADY,
   input wire logic        O_BVALID,
   input wire logic        I_BREADY,
   input wire logic [1:0]  O_BRESP,
   input wire logic        I_ARVALID,
   input wire logic        O_ARREADY,
   input wire logic [7:0]  I_ARADDR,
   input wire logic        O_RVALID,
   input wire logic        I_RREADY,
   input wire logic [31:0] O_RDATA,
   input wire logic [1:0]  O_RRESP
);
   // ********
   // handshakes
   // ********
   default clocking cb @(posedge I_MCLK); endclocking
   default disable iff (!I_RSTN);
   // the bench offers address and data together, so one edge takes both
   wire wr_go  = I_AWVALID && O_AWREADY && I_WVALID && O_WREADY;
   wire rd_go  = I_ARVALID && O_ARREADY;
   wire aw_bad = I_AWADDR > `MTC_OFF_CMP3 || I_AWADDR[1:0] != 2'h0;
   wire ar_bad = I_ARADDR > `MTC_OFF_CMP3 || I_ARADDR[1:0] != 2'h0;

   a_write_answer: assert property (wr_go |=> O_BVALID &&
      O_BRESP == ($past(aw_bad) ? `MTC_RESP_SLVERR : `MTC_RESP_OKAY))
      else $error("write response wrong or late");
   a_resp_held: assert property (O_BVALID && !I_BREADY |=> O_BVALID && $stable(O_BRESP))
      else $error("write response dropped early");
   a_write_closed: assert property (O_BVALID |-> !O_AWREADY && !O_WREADY)
      else $error("write accepted while response pending");
   a_resp_release: assert property (O_BVALID && I_BREADY |=> !O_BVALID && O_AWREADY && O_WREADY)
      else $error("write channel not reopened");
   a_read_answer: assert property (rd_go |=> O_RVALID &&
      O_RRESP == ($past(ar_bad) ? `MTC_RESP_SLVERR : `MTC_RESP_OKAY))
      else $error("read response wrong or late");
   a_read_held: assert property (O_RVALID && !I_RREADY |=> O_RVALID && $stable(O_RDATA))
      else $error("read data changed while waiting");
   a_read_closed: assert property (O_RVALID |-> !O_ARREADY)
      else $error("read accepted while data pending");
   a_read_release: assert property (O_RVALID && I_RREADY |=> !O_RVALID && O_ARREADY)
      else $error("read channel not reopened");
   a_refused_zero: assert property (rd_go && ar_bad |=> O_RDATA == 32'h0)
      else $error("refused read returned data");
endmodule

bind mtc_core mtc_core_chk u_chk (
   .I_MCLK, .I_RSTN, .I_AWVALID, .O_AWREADY, .I_AWADDR, .I_WVALID, .O_WREADY, .O_BVALID,
   .I_BREADY, .O_BRESP, .I_ARVALID, .O_ARREADY, .I_ARADDR, .O_RVALID, .I_RREADY, .O_RDATA,
   .O_RRESP
);

//--- test/mtc_core_test.sv
// self-checking bench of the motor timer counter core
// assumes mtc_link_model stands on the trigger link and an axi4-lite master is driven here
`timescale 1ns/1ns
`include "mtc_consts.svh"

module mtc_core_test;
   logic        I_MCLK = 1'b0, I_RSTN = 1'b0, I_AWVALID = 1'b0, I_WVALID = 1'b0;
   logic        I_BREADY = 1'b0, I_ARVALID = 1'b0, I_RREADY = 1'b0;
   logic [7:0]  I_AWADDR = 8'h00, I_ARADDR = 8'h00;
   logic [31:0] I_WDATA = 32'h0, O_RDATA, v, c1, c2;
   logic [15:0] seed = 16'h37c4;
   logic [6:0]  I_TRIG_IN;
   logic [1:0]  O_BRESP, O_RRESP;
   logic        O_AWREADY, O_WREADY, O_BVALID, O_ARREADY, O_RVALID, O_MTRIG;
   int          miscompares = 0, samples_checked = 0;

   mtc_core u_dut (
      .I_MCLK, .I_RSTN, .I_TRIG_IN, .I_AWVALID, .O_AWREADY, .I_AWADDR, .I_WVALID,
      .O_WREADY, .I_WDATA, .I_WSTRB(4'hf), .O_BVALID, .I_BREADY, .O_BRESP, .I_ARVALID,
      .O_ARREADY, .I_ARADDR, .O_RVALID, .I_RREADY, .O_RDATA, .O_RRESP, .O_MTRIG
   );
   mtc_link_model u_link (.i_clk(I_MCLK), .i_mtrig(O_MTRIG), .o_trig(I_TRIG_IN));

   always #50 I_MCLK = ~I_MCLK;

   // ********
   // helpers
   // ********
   task automatic chk(input string s, input logic [31:0] e, g);
      samples_checked++;
      if (g !== e) begin
         miscompares++;
         $display("MISMATCH %s expected %h seen %h", s, e, g);
      end
   endtask

   task automatic close_out;
      $display("checked %0d mismatched %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   task automatic give_up(input int n);
      if (n >= 40) begin
         chk("bus wait", 32'h0, 32'h1);
         close_out();
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = 2'h0);
      int n;
      n = 0;
      @(posedge I_MCLK);
      I_AWVALID <= 1'b1;
      I_WVALID <= 1'b1;
      I_AWADDR <= a;
      I_WDATA <= d;
      I_BREADY <= 1'b1;
      do begin
         @(posedge I_MCLK);
         n++;
         if (O_AWREADY) I_AWVALID <= 1'b0;
         if (O_WREADY) I_WVALID <= 1'b0;
      end while (!O_BVALID && n < 40);
      give_up(n);
      chk("write response", er, O_BRESP);
      I_BREADY <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er = 2'h0);
      int n;
      n = 0;
      @(posedge I_MCLK);
      I_ARVALID <= 1'b1;
      I_ARADDR <= a;
      I_RREADY <= 1'b1;
      do begin
         @(posedge I_MCLK);
         n++;
         if (O_ARREADY) I_ARVALID <= 1'b0;
      end while (!O_RVALID && n < 40);
      give_up(n);
      d = O_RDATA;
      chk("read response", er, O_RRESP);
      I_RREADY <= 1'b0;
   endtask

   task automatic rdc(input logic [7:0] a, input logic [31:0] e, input string s);
      logic [31:0] d;
      rd(a, d);
      chk(s, e, d);
   endtask

   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction

   // centre mode fires at both ends, so one event every reload steps
   function automatic int exp_gap(input int cms, arr, psc, rep);
      return (cms ? arr : arr + 1) * (psc + 1) * (rep + 1);
   endfunction

   // ********
   // scenarios
   // ********
   initial begin
      int m;
      int arr;
      int psc;
      int rep;
      int k;
      repeat (5) @(posedge I_MCLK);
      I_RSTN <= 1'b1;
      rdc(`MTC_OFF_RELOAD, 32'h0000ffff, "reload at reset");
      rdc(`MTC_OFF_CNT, 32'h0, "counter at reset");
      seed = lfsr(seed);
      wr(`MTC_OFF_CMP3, {16'h0, seed});
      rdc(`MTC_OFF_CMP3, {16'h0, seed}, "compare value");
      wr(8'h34, 32'h1, `MTC_RESP_SLVERR);
      wr(8'h06, 32'h1, `MTC_RESP_SLVERR);
      rd(8'h40, v, `MTC_RESP_SLVERR);
      chk("unmapped read", 32'h0, v);
      // master output pulses on each update event; m picks down, centre, up
      wr(`MTC_OFF_MODE, 32'h20);
      for (m = 0; m < 3; m++) begin
         seed = lfsr(seed);
         arr = 3 + seed[2:0];
         psc = seed[4:3] % 3;
         rep = seed[6:5] % 3;
         wr(`MTC_OFF_CFG, 32'h0);
         wr(`MTC_OFF_PSC, psc);
         wr(`MTC_OFF_RELOAD, arr);
         wr(`MTC_OFF_REP, rep);
         wr(`MTC_OFF_CNT, 32'h5);
         wr(`MTC_OFF_CFG, 2 << m);
         wr(`MTC_OFF_EVG, 32'h1);
         rdc(`MTC_OFF_CNT, m == 0 ? arr : 0, "counter after soft update");
         wr(`MTC_OFF_ISR, 32'h0);
         wr(`MTC_OFF_CFG, (2 << m) | 1);
         repeat (3 * exp_gap(m == 1, arr, psc, rep) + 30) @(posedge I_MCLK);
         chk("update spacing", exp_gap(m == 1, arr, psc, rep), u_link.gap);
         rd(`MTC_OFF_ISR, v);
         chk("update flag", 32'h1, v & 32'h1);
      end
      wr(`MTC_OFF_CFG, 32'h0);
      wr(`MTC_OFF_MODE, `MTC_SMS_EXTCLK);
      wr(`MTC_OFF_TRG, 32'h1);
      wr(`MTC_OFF_PSC, 32'h0);
      wr(`MTC_OFF_RELOAD, 32'hffff);
      wr(`MTC_OFF_EVG, 32'h1);
      wr(`MTC_OFF_CFG, 32'h1);
      seed = lfsr(seed);
      k = 1 + seed[2:0];
      u_link.pulse(0, k);
      rdc(`MTC_OFF_CNT, k, "event count");
      wr(`MTC_OFF_TRG, `MTC_TSRC_SOFT);
      u_link.pulse(0, 2);
      rdc(`MTC_OFF_CNT, k, "no count on soft source");
      wr(`MTC_OFF_MODE, `MTC_SMS_PAUSE);
      wr(`MTC_OFF_TRG, 32'h2);
      wr(`MTC_OFF_CNT, 32'h0);
      u_link.level(1, 1'b1);
      repeat (20) @(posedge I_MCLK);
      u_link.level(1, 1'b0);
      repeat (5) @(posedge I_MCLK);
      rd(`MTC_OFF_CNT, c1);
      repeat (9) @(posedge I_MCLK);
      rdc(`MTC_OFF_CNT, c1, "paused counter");
      chk("pause ran", 1, c1 > 16 && c1 < 26);
      wr(`MTC_OFF_CFG, 32'h0);
      wr(`MTC_OFF_MODE, `MTC_SMS_TRIGGER);
      wr(`MTC_OFF_TRG, 32'h3);
      rdc(`MTC_OFF_CNT, c1, "stopped counter");
      u_link.pulse(2, 1);
      rd(`MTC_OFF_CNT, c2);
      chk("resume from held value", 1, c2 > c1 && c2 < c1 + 12);
      u_link.pulse(2, 1);
      rd(`MTC_OFF_CNT, c2);
      chk("trigger never stops", 1, c2 > c1 + 8);
      wr(`MTC_OFF_MODE, `MTC_SMS_RESTART);
      wr(`MTC_OFF_TRG, 32'h4);
      for (m = 0; m < 2; m++) begin
         wr(`MTC_OFF_CFG, m ? 32'h1 : 32'h9);
         repeat (40) @(posedge I_MCLK);
         wr(`MTC_OFF_ISR, 32'h0);
         u_link.pulse(3, 1);
         rd(`MTC_OFF_CNT, c2);
         chk("restarted counter", 1, c2 < 12);
         rd(`MTC_OFF_ISR, v);
         chk("restart update flag", m, v & 32'h1);
      end
      wr(`MTC_OFF_MODE, 32'h10);
      repeat (2) @(posedge I_MCLK);
      chk("enable on master output", 1, O_MTRIG);
      // compare level on channel 3: counter is small and running up
      wr(`MTC_OFF_CMP3, 32'h0);
      wr(`MTC_OFF_MODE, 32'h70);
      repeat (2) @(posedge I_MCLK);
      chk("compare level high", 1, O_MTRIG);
      wr(`MTC_OFF_CMP3, 32'hffff);
      repeat (2) @(posedge I_MCLK);
      chk("compare level low", 0, O_MTRIG);
      close_out();
   end
endmodule

//--- test/mtc_link_model.sv
// linked timers around the core: they drive the trigger lines, watch the master output
// assumes the shared bus clock; trigger levels change just after a rising edge
`timescale 1ns/1ns

module mtc_link_model (
   input  wire logic  i_clk,
   input  wire logic  i_mtrig,
   output logic [6:0] o_trig
);
   int gap = 0;
   int run = 0;

   initial o_trig = 7'h00;

   // cycles between the last two master pulses
   always @(posedge i_clk) begin
      run <= i_mtrig ? 0 : run + 1;
      if (i_mtrig) begin
         gap <= run + 1;
      end
   end

   // three cycles each way, so the two-stage sampler never misses a level
   task automatic pulse(input int line, input int n);
      repeat (n) begin
         level(line, 1'b1);
         repeat (2) @(posedge i_clk);
         level(line, 1'b0);
         repeat (2) @(posedge i_clk);
      end
   endtask

   // plain levels only, never a both-edge signal
   task automatic level(input int line, input logic v);
      @(posedge i_clk);
      o_trig[line] <= v;
   endtask
endmodule
